// ### design/spi_link_params.svh
/*
  Constants of the framed 16-bit serial link slave: register offsets,
  field positions, reset values and fixed words.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SPI_LINK_PARAMS_SVH
`define SPI_LINK_PARAMS_SVH

// Link register offsets (10-bit word address space)
`define LF_CFG_ADDR 10'h1C8
`define LF_ERR_ADDR 10'h1D3
`define LF_SEL_ADDR 10'h3FF

// Fixed command and words
`define LF_RECOVER_CMD 16'hBA61
`define LF_SEL_GENERIC 16'h0004
`define LF_FILL_WORD 16'h0000
`define LF_DIAG_PAT 13'h1555

// Fault flag positions
`define LF_ERR_CKSYS 2
`define LF_ERR_FRAME 1
`define LF_ERR_WORD 0

// Link configuration fields
`define LF_CFG_IRQ_EN 15
`define LF_CFG_MODE_A 14
`define LF_CFG_WD_MSB 7
`define LF_CFG_WD_LSB 0
`define LF_WD_UNIT_PAD 4'h0

// Reset values
`define LF_FLAGS_RESET 3'h0
`define LF_CFG_RESET 16'h0000
`define LF_SEL_RESET 16'h0000

// Word framing and buffering
`define LF_LAST_BIT 4'hF
`define LF_FIFO_DEPTH 8

`endif

// ### design/spi_link_pkg.sv
/*
  Types of the framed serial link slave: phases, command word layout,
  write stream item and the complete state of the link engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spi_link_pkg;

  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DISCARD} phase_e;

  typedef struct packed {
    logic rd;
    logic [9:0] addr;
    logic [4:0] cnt;
  } cmd_word_s;

  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] data;
  } wr_item_s;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic mosi_m;
    logic mosi_s;
    logic ck_m;
    logic ck_s;
    phase_e phase;
    cmd_word_s cmd;
    logic [15:0] rx;
    logic [3:0] bitcnt;
    logic [5:0] words;
    logic [9:0] addr;
    logic [9:0] rd_addr;
    logic [15:0] tx;
    logic load_pend;
    logic err_state;
    logic recover;
    logic busy;
    logic oe;
    logic irq;
    logic [2:0] flags;
    logic [15:0] target;
    logic [15:0] cfg;
    logic [11:0] wd_cnt;
    logic hold_v;
    wr_item_s hold;
  } link_state_s;

endpackage : spi_link_pkg

// ### design/spi_link_slave.sv
/*
  Framed 16-bit serial link slave with fault monitor: command/data
  framing, word and frame checks, diagnostic answer word, frozen fault
  flags, error state and recovery read. Pins and the system clock
  monitor level are asynchronous and pass two flip-flops. Assumes
  clock polarity 0, phase 0 and a link clock far slower than i_clk_sys.
*/
`timescale 1ns/10ps
`include "spi_link_params.svh"
// Function
// - First word is command, rest data
// - Early select release short of count faults, except in gap-timed mode
// - Words beyond nonzero count fault, except in gap-timed mode
// - Zero count runs until select release, except in gap-timed mode, where the frame is discarded
// - Fault register holds three read-only flags
// - Write answer carries fixed thirteen-bit pattern
// - Answer low bits mirror fault flags
// - First captured fault freezes the register
// - Captured fault raises interrupt when enabled
// - Error state accepts only recovery read
// - Recovery sends one word, leaves error
// - Generic target returns code, clears flags
// - Other target returns filler, keeps flags
// - Select low without system clock faults
// - Gap-timed idle too long aborts transfer
// - Word not sixteen bits faults
// - Bit fault reported at sequence end
// - Fault register reads zero when healthy
// - Command word holds direction, address, count
// - Configured inactivity limit bounds word gap
module spi_link_slave import spi_link_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Serial link pins
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // System clock monitor and status
  input wire logic i_cksys_ok,
  output logic o_irq,
  output logic o_err_state,
  // Write stream toward the register space
  output logic o_wr_valid,
  output wr_item_s o_wr_item,
  input wire logic i_wr_ready,
  // Read port of the register space
  output logic [9:0] o_rd_addr,
  input wire logic [15:0] i_rd_data
);

  function automatic logic [15:0] read_word(input logic [9:0] a, input link_state_s st,
                                            input logic [15:0] ext);
    case (a)
      `LF_SEL_ADDR: read_word = st.target;
      `LF_CFG_ADDR: read_word = st.cfg;
      `LF_ERR_ADDR: read_word = {13'h0000, st.flags};
      default: read_word = ext;
    endcase
  endfunction : read_word

  link_state_s s;
  link_state_s n;
  logic fifo_ready;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;
  logic cs_fall;
  logic cs_rise;
  logic mode_a;
  logic word_done;
  logic last;
  logic clr_now;
  logic [15:0] w_in;
  logic [15:0] diag;
  logic [2:0] err_set;
  logic [2:0] flags_base;
  cmd_word_s c_in;

  always_comb begin
    n = s;
    n.cs_m = i_cs_b;
    n.cs_s = s.cs_m;
    n.cs_d = s.cs_s;
    n.sclk_m = i_sclk;
    n.sclk_s = s.sclk_m;
    n.sclk_d = s.sclk_s;
    n.mosi_m = i_mosi;
    n.mosi_s = s.mosi_m;
    n.ck_m = i_cksys_ok;
    n.ck_s = s.ck_m;
    sclk_rise = s.sclk_s & ~s.sclk_d;
    sclk_fall = ~s.sclk_s & s.sclk_d;
    cs_act = ~s.cs_s;
    cs_fall = s.cs_d & ~s.cs_s;
    cs_rise = ~s.cs_d & s.cs_s;
    mode_a = s.cfg[`LF_CFG_MODE_A];
    diag = {`LF_DIAG_PAT, s.flags};
    w_in = {s.rx[14:0], s.mosi_s};
    c_in = cmd_word_s'(w_in);
    word_done = sclk_rise & cs_act & (s.bitcnt == `LF_LAST_BIT);
    last = 1'h0;
    err_set = 3'h0;
    clr_now = 1'h0;
    n.oe = cs_act;
    if (s.hold_v && fifo_ready) begin
      n.hold_v = 1'h0;
    end
    if (cs_act && !s.ck_s) begin
      err_set[`LF_ERR_CKSYS] = 1'h1;
    end
    if (cs_fall && !(mode_a && s.busy)) begin
      n.bitcnt = 4'h0;
      n.tx = diag;
      n.phase = PH_CMD;
      n.words = 6'h00;
      n.load_pend = 1'h0;
    end
    if (sclk_fall && cs_act && s.bitcnt != 4'h0) begin
      n.tx = {s.tx[14:0], 1'h0};
    end
    // Read data is fetched half a link period late so the port has time to answer
    if (s.load_pend && ((sclk_fall && cs_act) || cs_fall)) begin
      n.tx = read_word(s.rd_addr, s, i_rd_data);
      n.load_pend = 1'h0;
      n.rd_addr = s.rd_addr + 10'h001;
      if (s.rd_addr == `LF_ERR_ADDR) begin
        clr_now = 1'h1;
      end
    end
    if (sclk_rise && cs_act) begin
      n.rx = w_in;
      n.bitcnt = s.bitcnt + 4'h1;
    end
    if (word_done) begin
      n.tx = diag;
      case (s.phase)
        PH_CMD: begin
          n.cmd = c_in;
          n.addr = c_in.addr;
          n.rd_addr = c_in.addr;
          n.words = 6'h00;
          if (s.err_state) begin
            if (w_in == `LF_RECOVER_CMD) begin
              n.phase = PH_DATA;
              n.recover = 1'h1;
              if (s.target == `LF_SEL_GENERIC) begin
                n.tx = {13'h0000, s.flags};
                clr_now = 1'h1;
              end else begin
                n.tx = `LF_FILL_WORD;
              end
            end else begin
              n.phase = PH_DISCARD;
            end
          end else if (mode_a && c_in.cnt == 5'h00) begin
            n.phase = PH_DISCARD;
          end else begin
            n.phase = PH_DATA;
            n.busy = mode_a;
            n.load_pend = c_in.rd;
          end
        end
        PH_DATA: begin
          n.words = s.words + 6'h01;
          n.addr = s.addr + 10'h001;
          if (s.recover) begin
            n.recover = 1'h0;
            n.err_state = 1'h0;
            n.phase = PH_DISCARD;
          end else if (s.cmd.cnt != 5'h00 && s.words == {1'h0, s.cmd.cnt}) begin
            err_set[`LF_ERR_FRAME] = 1'h1;
            n.phase = PH_DISCARD;
          end else begin
            last = (s.cmd.cnt != 5'h00) && (s.words + 6'h01 == {1'h0, s.cmd.cnt});
            n.load_pend = s.cmd.rd && !last;
            if (last && mode_a) begin
              n.busy = 1'h0;
              n.phase = PH_CMD;
            end
            if (!s.cmd.rd) begin
              case (s.addr)
                `LF_SEL_ADDR: n.target = w_in;
                `LF_CFG_ADDR: n.cfg = w_in;
                `LF_ERR_ADDR: ;
                default: begin
                  // A word still waiting on a stalled stream is an overrun
                  if (n.hold_v) begin
                    err_set[`LF_ERR_FRAME] = 1'h1;
                  end else begin
                    n.hold_v = 1'h1;
                    n.hold.addr = s.addr;
                    n.hold.data = w_in;
                  end
                end
              endcase
            end
          end
        end
        default: ;
      endcase
    end
    if (cs_rise) begin
      n.bitcnt = 4'h0;
      if (s.bitcnt != 4'h0) begin
        err_set[`LF_ERR_WORD] = 1'h1;
      end
      if (!(mode_a && s.busy)) begin
        if (!mode_a && s.phase == PH_DATA && !s.recover && s.cmd.cnt != 5'h00
            && s.words < {1'h0, s.cmd.cnt}) begin
          err_set[`LF_ERR_FRAME] = 1'h1;
        end
        n.phase = PH_CMD;
        n.load_pend = 1'h0;
        n.recover = 1'h0;
      end
    end
    if (mode_a && s.busy && !sclk_rise) begin
      n.wd_cnt = s.wd_cnt + 12'h001;
    end else begin
      n.wd_cnt = 12'h000;
    end
    if (mode_a && s.busy && s.cfg[`LF_CFG_WD_MSB:`LF_CFG_WD_LSB] != 8'h00
        && s.wd_cnt >= {s.cfg[`LF_CFG_WD_MSB:`LF_CFG_WD_LSB], `LF_WD_UNIT_PAD}) begin
      err_set[`LF_ERR_FRAME] = 1'h1;
      n.busy = 1'h0;
      n.phase = PH_CMD;
      n.load_pend = 1'h0;
    end
    // freeze, a new fault wins over a clear
    flags_base = clr_now ? 3'h0 : s.flags;
    n.flags = flags_base;
    if (flags_base == 3'h0 && err_set != 3'h0) begin
      n.flags = err_set;
      n.err_state = 1'h1;
      n.recover = 1'h0;
      n.phase = PH_DISCARD;
      n.busy = 1'h0;
      n.load_pend = 1'h0;
    end
    n.irq = n.err_state & n.cfg[`LF_CFG_IRQ_EN];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.cs_m <= 1'h1;
      s.cs_s <= 1'h1;
      s.cs_d <= 1'h1;
      s.flags <= `LF_FLAGS_RESET;
      s.cfg <= `LF_CFG_RESET;
      s.target <= `LF_SEL_RESET;
    end else begin
      s <= n;
    end
  end

  word_fifo #(
    .WIDTH($bits(wr_item_s)),
    .DEPTH(`LF_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_valid(s.hold_v),
    .i_data(s.hold),
    .o_ready(fifo_ready),
    .o_valid(o_wr_valid),
    .o_data(o_wr_item),
    .i_ready(i_wr_ready)
  );

  assign o_miso = s.tx[15];
  assign o_miso_oe = s.oe;
  assign o_irq = s.irq;
  assign o_err_state = s.err_state;
  assign o_rd_addr = s.rd_addr;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  property p_diag_hi;
    word_done && s.phase == PH_DATA && !s.cmd.rd && !s.recover |=> s.tx[15:3] == `LF_DIAG_PAT;
  endproperty
  a_diag_hi: assert property (p_diag_hi) else $error("diagnostic pattern missing");

  property p_diag_lo;
    word_done && s.phase == PH_DATA && !s.cmd.rd && !s.recover |=> s.tx[2:0] == $past(s.flags);
  endproperty
  a_diag_lo: assert property (p_diag_lo) else $error("diagnostic flags differ");

  property p_freeze;
    s.flags != 3'h0 && !clr_now |=> s.flags == $past(s.flags);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen flags changed");

  property p_irq;
    err_set != 3'h0 && s.flags == 3'h0 && !clr_now && s.cfg[`LF_CFG_IRQ_EN]
      |=> o_irq && o_err_state;
  endproperty
  a_irq: assert property (p_irq) else $error("fault without interrupt");

  property p_only_recover;
    word_done && s.phase == PH_CMD && s.err_state && w_in != `LF_RECOVER_CMD
      |=> s.phase == PH_DISCARD && s.err_state;
  endproperty
  a_only_recover: assert property (p_only_recover) else $error("command taken in error");

  property p_recover_done;
    word_done && s.recover && err_set == 3'h0 |=> !o_err_state ##1 !o_irq;
  endproperty
  a_recover_done: assert property (p_recover_done) else $error("error state kept");

  property p_recover_sel;
    word_done && s.phase == PH_CMD && s.err_state && w_in == `LF_RECOVER_CMD
      && s.target == `LF_SEL_GENERIC && err_set == 3'h0
      |=> s.flags == 3'h0 && s.tx == {13'h0000, $past(s.flags)};
  endproperty
  a_recover_sel: assert property (p_recover_sel) else $error("code not returned");

  property p_recover_keep;
    word_done && s.phase == PH_CMD && s.err_state && w_in == `LF_RECOVER_CMD
      && s.target != `LF_SEL_GENERIC |=> s.flags == $past(s.flags) && s.recover;
  endproperty
  a_recover_keep: assert property (p_recover_keep) else $error("flags lost");

  property p_cksys;
    cs_act && !s.ck_s && s.flags == 3'h0 |=> s.flags[`LF_ERR_CKSYS];
  endproperty
  a_cksys: assert property (p_cksys) else $error("clock fault missed");

  property p_word_err;
    cs_rise && s.bitcnt != 4'h0 && s.flags == 3'h0 && !clr_now |=> s.flags[`LF_ERR_WORD];
  endproperty
  a_word_err: assert property (p_word_err) else $error("bit count fault missed");

  property p_short_frame;
    cs_rise && !mode_a && s.phase == PH_DATA && !s.recover && s.cmd.cnt != 5'h00
      && s.words < {1'h0, s.cmd.cnt} && s.flags == 3'h0 && !clr_now
      |=> s.flags[`LF_ERR_FRAME] && o_err_state;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame missed");

  c_recover: cover property (word_done && s.recover);
  c_push: cover property (o_wr_valid && i_wr_ready);
  c_excess: cover property (word_done && s.phase == PH_DATA && s.cmd.cnt != 5'h00
                            && s.words == {1'h0, s.cmd.cnt});

endmodule : spi_link_slave

// ### design/word_fifo.sv
/*
  Shift-register FIFO with valid/ready on both sides; head entry and
  flags are registers. Assumes one clock and an active-low async reset.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int CW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic valid;
    logic full;
  } fifo_st_s;

  fifo_st_s s;
  fifo_st_s n;
  logic push;
  logic pop;
  logic [CW-1:0] wr_idx;

  always_comb begin
    n = s;
    pop = s.valid & i_ready;
    push = i_valid & ~s.full;
    wr_idx = s.cnt - {{(CW-1){1'h0}}, pop};
    // Head always sits in entry 0, so the output needs no read mux
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        n.mem[i] = (i == DEPTH - 1) ? '0 : s.mem[(i + 1) % DEPTH];
      end
      if (push && (CW'(i) == wr_idx)) begin
        n.mem[i] = i_data;
      end
    end
    n.cnt = wr_idx + {{(CW-1){1'h0}}, push};
    n.valid = (n.cnt != '0);
    n.full = (n.cnt == CW'(DEPTH));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_ready = ~s.full;
  assign o_valid = s.valid;
  assign o_data = s.mem[0];

endmodule : word_fifo

// ### test/spi_link_slave_tb_top.sv
/*
  Self-checking bench of the link slave: a table of plain frames, then
  faults, recovery, buffering and gap-timed frames.
  Assumes the master model and the design package are compiled first.
*/
`timescale 1ns/10ps
module spi_link_slave_tb_top import spi_link_pkg::*;;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] data;
    logic [15:0] ans;
    logic push;
  } row_s;
  logic clk_sys = 1'b0;
  logic rst_b, cksys_ok, wr_ready, cs_b, sclk, mosi, miso, miso_oe, irq, err_state, wr_valid;
  wr_item_s wr_item;
  logic [9:0] rd_addr;
  logic [15:0] rd_data;
  logic [15:0] ans [0:15];
  wr_item_s got [$];
  int miscompares = 0;
  int tests_run = 0;
  row_s rows [5] = '{
    '{16'h7FE1, 16'h0004, 16'hAAA8, 1'b0},
    '{16'h3281, 16'h1234, 16'hAAA8, 1'b1},
    '{16'hFFE1, 16'h0000, 16'h0004, 1'b0},
    '{16'hBA61, 16'h0000, 16'h0000, 1'b0},
    '{16'hA001, 16'h0000, 16'hF100, 1'b0}
  };

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rd_data <= {6'h3C, rd_addr};
    if (wr_valid && wr_ready) begin
      got.push_back(wr_item);
    end
  end

  spi_link_slave DUT (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sclk(sclk), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_cksys_ok(cksys_ok), .o_irq(irq),
    .o_err_state(err_state), .o_wr_valid(wr_valid), .o_wr_item(wr_item),
    .i_wr_ready(wr_ready), .o_rd_addr(rd_addr), .i_rd_data(rd_data)
  );
  // A released answer line shows the inverse of its last bit, so stale data never passes
  spi_master_model MST (
    .i_clk_sys(clk_sys), .o_cs_b(cs_b), .o_sclk(sclk), .o_mosi(mosi),
    .i_miso(miso_oe ? miso : ~miso)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic frame(input logic [15:0] c, input int n, input logic [15:0] d, input int lb);
    MST.frame_start();
    MST.xfer(c, 16, ans[0]);
    for (int k = 1; k <= n; k++) begin
      MST.xfer(d + 16'(k - 1), (k == n) ? lb : 16, ans[k]);
    end
    MST.frame_end();
  endtask : frame

  task automatic recover(input logic [15:0] code);
    frame(16'hBA61, 1, 16'h0000, 16);
    chk("recovery word", ans[1], code);
    chk("err_state", err_state, 1'b0);
    chk("irq", irq, 1'b0);
  endtask : recover

  // explicit count on the clear-on-read register
  task automatic read_flags(input logic [15:0] exp);
    frame(16'hBA61, 1, 16'h0000, 16);
    chk("fault flags", ans[1], exp);
  endtask : read_flags

  task automatic fault(input logic exp_irq);
    chk("err_state", err_state, 1'b1);
    chk("irq", irq, exp_irq);
  endtask : fault

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Nearly four times the expected run length
  initial begin
    #700000;
    miscompares++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    cksys_ok = 1'b1;
    wr_ready = 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("miso_oe", miso_oe, 1'b0);
    chk("err_state", err_state, 1'b0);
    chk("wr_valid", wr_valid, 1'b0);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("test reset done");
    foreach (rows[i]) begin
      got.delete();
      frame(rows[i].cmd, 1, rows[i].data, 16);
      chk("command answer", ans[0], 16'hAAA8);
      chk("data answer", ans[1], rows[i].ans);
      if (rows[i].push) begin
        chk("item", got.size() > 0 ? got[0] : 26'h0, {rows[i].cmd[14:5], rows[i].data});
      end
    end
    $display("test table done");
    got.delete();
    frame(16'h0200, 3, 16'h5000, 16);
    chk("items", got.size(), 3);
    foreach (got[i]) chk("item", got[i], {10'(16 + i), 16'(16'h5000 + i)});
    $display("test open frame done");
    wr_ready <= 1'b0;
    got.delete();
    frame(16'h0809, 9, 16'h6000, 16);
    chk("err_state", err_state, 1'b0);
    chk("wr_valid", wr_valid, 1'b1);
    wr_ready <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("items", got.size(), 9);
    foreach (got[i]) chk("item", got[i], {10'(64 + i), 16'(16'h6000 + i)});
    chk("wr_valid", wr_valid, 1'b0);
    $display("test buffer done");
    frame(16'h0402, 1, 16'h7000, 16);
    fault(1'b0);
    got.delete();
    frame(16'h0401, 1, 16'h7100, 16);
    chk("command answer", ans[0], 16'hAAAA);
    frame(16'h0401, 1, 16'h7100, 8);
    repeat (10) @(posedge clk_sys);
    chk("items", got.size(), 0);
    recover(16'h0002);
    read_flags(16'h0000);
    $display("test short frame done");
    frame(16'h7FE1, 1, 16'h0001, 16);
    frame(16'h3901, 1, 16'h8000, 16);
    frame(16'h0401, 2, 16'h7200, 16);
    fault(1'b1);
    recover(16'h0000);
    read_flags(16'h0002);
    $display("test long frame done");
    frame(16'h0400, 1, 16'h7300, 8);
    fault(1'b1);
    recover(16'h0000);
    read_flags(16'h0001);
    $display("test partial word done");
    cksys_ok <= 1'b0;
    frame(16'h0401, 0, 16'h0000, 16);
    cksys_ok <= 1'b1;
    fault(1'b1);
    recover(16'h0000);
    read_flags(16'h0004);
    $display("test clock missing done");
    frame(16'h3901, 1, 16'h4004, 16);
    MST.frame_start();
    MST.xfer(16'h0402, 16, ans[0]);
    MST.xfer(16'h7400, 16, ans[1]);
    chk("miso_oe", miso_oe, 1'b1);
    repeat (150) @(posedge clk_sys);
    fault(1'b0);
    MST.frame_end();
    recover(16'h0000);
    read_flags(16'h0002);
    frame(16'h3901, 1, 16'h0000, 16);
    $display("test gap timed done");
    frame(16'h0400, 1, 16'h7500, 8);
    fault(1'b0);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("err_state", err_state, 1'b0);
    chk("irq", irq, 1'b0);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    read_flags(16'h0000);
    chk("command answer", ans[0], 16'hAAA8);
    $display("test second reset done");
    final_report();
  end
endmodule : spi_link_slave_tb_top

// ### test/spi_master_model.sv
/*
  Behavioural link master: framed 16-bit words, MSB first, clock mode 0.
  Assumes the bench calls its tasks one at a time, in step with i_clk_sys.
*/
`timescale 1ns/10ps
module spi_master_model (
  // System clock
  input wire logic i_clk_sys,
  // Link pins
  output logic o_cs_b,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso
);
  // Half of the 160 ns link period in system cycles
  localparam int HALF = 10;

  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  task automatic frame_start();
    @(posedge i_clk_sys);
    o_cs_b <= 1'b0;
    repeat (HALF) @(posedge i_clk_sys);
  endtask : frame_start

  // A short nbits leaves a partial word on purpose
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    for (int i = 15; i > 15 - nbits; i--) begin
      o_mosi <= w[i];
      repeat (HALF) @(posedge i_clk_sys);
      r[i] = i_miso;
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
  endtask : xfer

  // Released data line flips so a stale bit is never mistaken for data
  task automatic frame_end();
    repeat (HALF) @(posedge i_clk_sys);
    o_cs_b <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (HALF) @(posedge i_clk_sys);
  endtask : frame_end
endmodule : spi_master_model
